// ===== rtl/acc_pkg.sv
// constants shared by the converter option control and its sequencer
package acc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPT_LOW_ADDR  = 8'h3a;
    localparam logic [7:0]  OPT_HIGH_ADDR = 8'h3b;
    localparam logic [15:0] OPT_RESET     = 16'h2000;
    localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

    // field positions inside the upper byte
    localparam int REPEAT_BIT  = 7;
    localparam int TRIGGER_BIT = 6;
    localparam int RANGE_BIT   = 5;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ         = 20000000;
    localparam int SET_TIME_MS    = 10;
    localparam int REPEAT_TIME_S  = 1;
    localparam int CHAN_COUNT     = 8;
    localparam int SET_CYCLES     = CLK_HZ / 1000 * SET_TIME_MS;
    localparam int CHAN_CYCLES    = SET_CYCLES / CHAN_COUNT;
    localparam int REPEAT_CYCLES  = CLK_HZ * REPEAT_TIME_S;

    // channel codes in conversion order
    typedef enum logic [2:0] {
        CH_BATTERY_VOLTAGE   = 3'h0,
        CH_SYSTEM_VOLTAGE    = 3'h1,
        CH_CHARGE_CURRENT    = 3'h2,
        CH_DISCHARGE_CURRENT = 3'h3,
        CH_INPUT_CURRENT     = 3'h4,
        CH_SYSTEM_POWER      = 3'h5,
        CH_BUS_VOLTAGE       = 3'h6,
        CH_COMPARATOR_INPUT  = 3'h7
    } acc_chan_t;

    // sequencer states
    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_CONV = 1'b1
    } acc_seq_state_t;

endpackage : acc_pkg

// ===== rtl/acc_seq_if.sv
// control and result signals between option control and sequencer
`timescale 1ns/100ps
interface acc_seq_if;
    logic                 go;
    logic                 abort;
    logic [7:0]           chanEnable;
    logic                 busy;
    logic                 done;
    logic                 resultStrobe;
    acc_pkg::acc_chan_t   channel;

    modport ctl (output go, abort, chanEnable,
                 input  busy, done, resultStrobe, channel);
    modport seq (input  go, abort, chanEnable,
                 output busy, done, resultStrobe, channel);
endinterface : acc_seq_if

// ===== rtl/acc_sequencer.sv
// walks the enabled channels in fixed order, one slot per channel
`timescale 1ns/100ps
module acc_sequencer #(
    parameter int CHAN_CYCLES = acc_pkg::CHAN_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    acc_seq_if.seq    bus
);

    acc_pkg::acc_seq_state_t state;
    acc_pkg::acc_chan_t      walkChan;
    logic [31:0]             slotCount;
    logic                    slotEnd;
    logic                    lastChan;
    logic                    chanOn;

    // ------------------------------------------------------------------
    // slot decode
    // ------------------------------------------------------------------
    assign chanOn   = bus.chanEnable[walkChan];
    assign lastChan = (walkChan == acc_pkg::CH_COMPARATOR_INPUT);
    // slot time from set time
    // a disabled channel ends its slot at once and is skipped
    assign slotEnd  = !chanOn || (slotCount == 32'(CHAN_CYCLES - 1));

    // ------------------------------------------------------------------
    // channel walk
    // ------------------------------------------------------------------
    // fixed channel order
    always_ff @(posedge clk)
    begin
        if (!rst_n || bus.abort)
        begin
            state        <= acc_pkg::SEQ_IDLE;
            walkChan     <= acc_pkg::CH_BATTERY_VOLTAGE;
            bus.channel  <= acc_pkg::CH_BATTERY_VOLTAGE;
            slotCount    <= 32'h0;
            bus.done     <= 1'b0;
            bus.resultStrobe <= 1'b0;
        end
        else
        begin
            bus.done         <= 1'b0;
            bus.resultStrobe <= 1'b0;
            unique case (state)
                acc_pkg::SEQ_IDLE:
                begin
                    slotCount   <= 32'h0;
                    walkChan    <= acc_pkg::CH_BATTERY_VOLTAGE;
                    if (bus.go)
                        state <= acc_pkg::SEQ_CONV;
                end
                acc_pkg::SEQ_CONV:
                begin
                    slotCount <= slotEnd ? 32'h0 : slotCount + 32'h1;
                    // only enabled results update
                    // result channel is the slot just ended, not the next
                    if (slotEnd && chanOn)
                    begin
                        bus.resultStrobe <= 1'b1;
                        bus.channel      <= walkChan;
                    end
                    if (slotEnd && lastChan)
                    begin
                        state    <= acc_pkg::SEQ_IDLE;
                        bus.done <= 1'b1;
                    end
                    else if (slotEnd)
                        walkChan <= acc_pkg::acc_chan_t'(walkChan + 3'h1);
                end
            endcase
        end
    end

    assign bus.busy = (state == acc_pkg::SEQ_CONV);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] lastStrobed;
    logic       anyStrobed;
    always_ff @(posedge clk)
    begin
        if (!rst_n || !bus.busy)
            anyStrobed <= 1'b0;
        else if (bus.resultStrobe)
            anyStrobed <= 1'b1;
        if (bus.resultStrobe)
            lastStrobed <= bus.channel;
    end

    a_order_rising: assert property (
        bus.resultStrobe && anyStrobed
            |-> bus.channel > lastStrobed)
        else $error("result channels out of order");

    a_skip_disabled: assert property (
        bus.resultStrobe |-> bus.chanEnable[bus.channel])
        else $error("result strobe for a disabled channel");

    sequence setStart;
        $rose(bus.busy);
    endsequence

    a_slot_length: assert property (
        setStart ##0 bus.chanEnable[0] && !bus.abort
            |-> !bus.resultStrobe [*8])
        else $error("channel slot shorter than its conversion time");

endmodule : acc_sequencer

// ===== rtl/acc_converter_control.sv
// converter option register, trigger, repeat timer and low power control
`timescale 1ns/100ps
// How it works
// - enabled channels are converted and their results updated in the order battery voltage, system voltage, charge current, discharge current, input current, system power, bus voltage, comparator input.
// - the converter stays idle whenever the device is in low power mode.
// - enabling the converter while on battery only takes the device out of low power mode.
// - a conversion set with all eight channels enabled takes 10 ms, shared evenly among the slots; a disabled channel's slot ends at once.
// - with repeat select at 0, writing the trigger bit to 1 runs exactly one conversion set.
// - with repeat select at 1, a conversion set is started once every second.
// - the host sets the trigger bit to start, and the device clears it after a one-shot set ends.
// - the range select bit picks 2.04 V full scale at 0 and 3.06 V at 1, and resets to 1.
// - each lower byte bit enables one channel, all cleared at reset.
module acc_converter_control #(
    parameter int SET_CYCLES    = acc_pkg::SET_CYCLES,
    parameter int REPEAT_CYCLES = acc_pkg::REPEAT_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               regWrite,
    input  wire logic [7:0]         regAddr,
    input  wire logic [7:0]         regWrData,
    output logic      [7:0]         regRdData,
    input  wire logic               lowPowerRequest,
    input  wire logic               batteryOnly,
    output logic                    lowPowerMode,
    output logic                    fullScaleHigh,
    output logic                    converterActive,
    output logic                    resultStrobe,
    output acc_pkg::acc_chan_t      resultChannel
);

    acc_seq_if seqBus ();

    logic [7:0]  optLow;
    logic [7:0]  optHigh;
    logic [1:0]  lpSync;
    logic [1:0]  batSync;
    logic [31:0] repeatTimer;
    logic        writeLow;
    logic        writeHigh;
    logic        repeatMode;
    logic        trigger;
    logic        clearTrigger;
    logic        startSet;
    logic        next_lowPowerMode;
    logic [7:0]  readSel;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign writeLow   = regWrite && (regAddr == acc_pkg::OPT_LOW_ADDR);
    assign writeHigh  = regWrite && (regAddr == acc_pkg::OPT_HIGH_ADDR);
    assign repeatMode = optHigh[acc_pkg::REPEAT_BIT];
    assign trigger    = optHigh[acc_pkg::TRIGGER_BIT];
    assign readSel    = (regAddr == acc_pkg::OPT_LOW_ADDR)  ? optLow  :
                        (regAddr == acc_pkg::OPT_HIGH_ADDR) ? optHigh :
                        acc_pkg::UNMAPPED_DATA;

    // ------------------------------------------------------------------
    // option register
    // ------------------------------------------------------------------
    // self clear after a one-shot set
    assign clearTrigger = seqBus.done && !repeatMode;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            optLow <= acc_pkg::OPT_RESET[7:0];
        else if (writeLow)
            optLow <= regWrData;
    end

    // range bit resets to the wide scale; a host write wins over clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            optHigh <= acc_pkg::OPT_RESET[15:8];
        else if (writeHigh)
            optHigh <= regWrData;
        else if (clearTrigger)
            optHigh[acc_pkg::TRIGGER_BIT] <= 1'b0;
    end

    // read data is registered every cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            regRdData <= 8'h00;
        else
            regRdData <= readSel;
    end

    // ------------------------------------------------------------------
    // pin synchronisers and low power mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lpSync  <= 2'b00;
            batSync <= 2'b00;
        end
        else
        begin
            lpSync  <= {lpSync[0], lowPowerRequest};
            batSync <= {batSync[0], batteryOnly};
        end
    end

    // enabling the converter on battery leaves low power mode
    assign next_lowPowerMode = lpSync[1] && !(trigger && batSync[1]);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lowPowerMode <= 1'b0;
        else
            lowPowerMode <= next_lowPowerMode;
    end

    // ------------------------------------------------------------------
    // set start and repeat timer
    // ------------------------------------------------------------------
    // one-shot start; continuous start when the timer runs out
    assign startSet = trigger && !lowPowerMode && !seqBus.busy
                      && !seqBus.done
                      && (!repeatMode || repeatTimer == 32'h0);

    // one second from start of set to start of the next
    always_ff @(posedge clk)
    begin
        if (!rst_n || !trigger || !repeatMode)
            repeatTimer <= 32'h0;
        else if (startSet)
            repeatTimer <= 32'(REPEAT_CYCLES - 1);
        else if (repeatTimer != 32'h0)
            repeatTimer <= repeatTimer - 32'h1;
    end

    // low power mode or a cleared trigger stops the set
    assign seqBus.go         = startSet;
    assign seqBus.abort      = lowPowerMode || !trigger;
    assign seqBus.chanEnable = optLow;

    // ------------------------------------------------------------------
    // sequencer and outputs
    // ------------------------------------------------------------------
    acc_sequencer #(
        .CHAN_CYCLES (SET_CYCLES / acc_pkg::CHAN_COUNT)
    ) u_sequencer (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (seqBus.seq)
    );

    // full scale select follows the range bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fullScaleHigh   <= acc_pkg::OPT_RESET[8 + acc_pkg::RANGE_BIT];
            converterActive <= 1'b0;
            resultStrobe    <= 1'b0;
            resultChannel   <= acc_pkg::CH_BATTERY_VOLTAGE;
        end
        else
        begin
            fullScaleHigh   <= optHigh[acc_pkg::RANGE_BIT];
            converterActive <= seqBus.busy;
            resultStrobe    <= seqBus.resultStrobe;
            resultChannel   <= seqBus.channel;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_trigger_self_clear: assert property (
        seqBus.done && !repeatMode && !writeHigh |=> !trigger)
        else $error("trigger not cleared after one-shot set");

    a_lowpower_idle: assert property (
        lowPowerMode |=> !seqBus.busy ##1 !converterActive)
        else $error("converter running in low power mode");

    a_battery_exit: assert property (
        trigger && batSync[1] |=> !lowPowerMode)
        else $error("low power mode kept with converter enabled");

    a_range_follow: assert property (
        writeHigh |=> ##1
            fullScaleHigh == $past(regWrData[acc_pkg::RANGE_BIT], 2))
        else $error("full scale output does not follow range write");

    a_oneshot_single: assert property (
        seqBus.done && !repeatMode && !writeHigh
            |=> !seqBus.go [*4])
        else $error("one-shot mode started a second set");

    a_repeat_wait: assert property (
        seqBus.go && repeatMode && trigger
            |=> repeatTimer == 32'(REPEAT_CYCLES - 1))
        else $error("repeat timer not loaded at set start");

endmodule : acc_converter_control

// ===== tb/acc_host_model.sv
// host model driving the byte register port of the converter control
`timescale 1ns/100ps
module acc_host_model (
    input  wire logic       clk,
    output logic            regWrite,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData
);
    // idle port values from time zero
    initial
    begin
        regWrite  = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // host register write
    // one write, strobe high across exactly one rising edge
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrite  = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(negedge clk);
        regWrite  = 1'b0;
        regWrData = ~d; // data no longer qualified
    endtask : write_byte

    // read data is registered one edge after the address
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        d = regRdData;
    endtask : read_byte
endmodule : acc_host_model

// ===== tb/adc_conversion_control_tb.sv
// self-checking bench for the converter option control
`timescale 1ns/100ps
module adc_conversion_control_tb;
    localparam int SET_CYC = 64;
    localparam int REP_CYC = 400;
    logic               clk;
    logic               rst_n;
    logic               regWrite;
    logic [7:0]         regAddr;
    logic [7:0]         regWrData;
    logic [7:0]         regRdData;
    logic               lowPowerRequest;
    logic               batteryOnly;
    logic               lowPowerMode;
    logic               fullScaleHigh;
    logic               converterActive;
    logic               resultStrobe;
    acc_pkg::acc_chan_t resultChannel;
    acc_pkg::acc_chan_t expQ[$];
    int                 mismatches;
    int                 totalChecks;
    logic [7:0]         rd;

    acc_converter_control #(
        .SET_CYCLES    (SET_CYC),
        .REPEAT_CYCLES (REP_CYC)
    ) u_dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .regWrite        (regWrite),
        .regAddr         (regAddr),
        .regWrData       (regWrData),
        .regRdData       (regRdData),
        .lowPowerRequest (lowPowerRequest),
        .batteryOnly     (batteryOnly),
        .lowPowerMode    (lowPowerMode),
        .fullScaleHigh   (fullScaleHigh),
        .converterActive (converterActive),
        .resultStrobe    (resultStrobe),
        .resultChannel   (resultChannel)
    );

    acc_host_model u_host (
        .clk       (clk),
        .regWrite  (regWrite),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regRdData (regRdData)
    );

    // clock at 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic fail(input string m);
        mismatches++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        totalChecks++;
        if (g !== e)
            fail($sformatf("byte %h expected %h", g, e));
    endtask : chk8

    task automatic chkBit(input logic g, input logic e, input string m);
        totalChecks++;
        if (g !== e)
            fail(m);
    endtask : chkBit

    task automatic chkChan(input acc_pkg::acc_chan_t g,
                           input acc_pkg::acc_chan_t e);
        totalChecks++;
        if (g !== e)
            fail($sformatf("channel %0d expected %0d", g, e));
    endtask : chkChan

    task automatic conclude();
        if (mismatches == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // each result strobe takes the oldest expected channel, mid-cycle
    always @(negedge clk)
    begin
        if (resultStrobe === 1'b1)
        begin
            if (expQ.size() == 0)
                fail("unexpected result strobe");
            else
                chkChan(resultChannel, expQ.pop_front());
        end
    end

    // poll the upper byte until the trigger bit drops, bounded
    task automatic wait_clear(input logic [7:0] hi);
        int n;
        n = 0;
        rd = 8'hff;
        while (rd[acc_pkg::TRIGGER_BIT] !== 1'b0 && n < 300)
        begin
            u_host.read_byte(acc_pkg::OPT_HIGH_ADDR, rd);
            n++;
        end
        chk8(rd, hi);
        repeat (4) @(negedge clk);
        chkBit(expQ.size() == 0, 1'b1, "results missing");
    endtask : wait_clear

    // one-shot set: only enabled channels, ascending order
    task automatic one_shot(input logic [7:0] en);
        u_host.write_byte(acc_pkg::OPT_LOW_ADDR, en);
        for (int i = 0; i < 8; i++)
            if (en[i])
                expQ.push_back(acc_pkg::acc_chan_t'(i));
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h40);
        repeat (2) @(negedge clk);
        chkBit(converterActive, 1'b1, "set not running");
        wait_clear(8'h00);
    endtask : one_shot

    initial
    begin
        rst_n = 1'b0;
        lowPowerRequest = 1'b0;
        batteryOnly = 1'b0;
        mismatches = 0;
        totalChecks = 0;
        void'($urandom(21));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        u_host.read_byte(acc_pkg::OPT_LOW_ADDR, rd);
        chk8(rd, 8'h00);
        u_host.read_byte(acc_pkg::OPT_HIGH_ADDR, rd);
        chk8(rd, 8'h20);
        chkBit(fullScaleHigh, 1'b1, "full scale reset");
        u_host.read_byte(8'h3c, rd);
        chk8(rd, acc_pkg::UNMAPPED_DATA);
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h00);
        @(negedge clk);
        chkBit(fullScaleHigh, 1'b0, "full scale low");
        one_shot(8'hff);
        one_shot(8'h00);
        for (int k = 0; k < 4; k++)
            one_shot(8'($urandom()));
        u_host.write_byte(acc_pkg::OPT_LOW_ADDR, 8'h81);
        repeat (2)
        begin
            expQ.push_back(acc_pkg::CH_BATTERY_VOLTAGE);
            expQ.push_back(acc_pkg::CH_COMPARATOR_INPUT);
        end
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'hc0);
        repeat (REP_CYC + REP_CYC / 2) @(negedge clk);
        u_host.read_byte(acc_pkg::OPT_HIGH_ADDR, rd);
        chk8(rd, 8'hc0);
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h80);
        wait_clear(8'h80);
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h00);
        lowPowerRequest = 1'b1;
        repeat (4) @(negedge clk);
        chkBit(lowPowerMode, 1'b1, "low power entry");
        u_host.write_byte(acc_pkg::OPT_LOW_ADDR, 8'h01);
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h40);
        repeat (SET_CYC) @(negedge clk);
        chkBit(converterActive, 1'b0, "active in low power");
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h00);
        batteryOnly = 1'b1;
        repeat (4) @(negedge clk);
        expQ.push_back(acc_pkg::CH_BATTERY_VOLTAGE);
        u_host.write_byte(acc_pkg::OPT_HIGH_ADDR, 8'h40);
        repeat (4) @(negedge clk);
        chkBit(lowPowerMode, 1'b0, "low power exit");
        wait_clear(8'h00);
        conclude();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule : adc_conversion_control_tb
